//--- asr_readout.sv
// Serial result readout: conversion timing in core domain, shifter in shift-clock domain.
// Assumes the host drives convert_start and shift_clk; results arrive on conv_data with conv_valid.
`timescale 1ns/100ps
module asr_readout #(
  parameter int CONV_CYCLES = asr_pkg::CONV_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        shift_clk,
  input  wire logic        chain_select,
  input  wire logic        convert_start,
  input  wire logic        read_select_or_link_in,
  input  wire logic [19:0] conv_data,
  input  wire logic        conv_valid,
  output logic             conv_ready,
  output logic             busy,
  output logic             serial_result_out_o,
  output logic             serial_result_out_oe
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] cnv_sync_r;
  logic [1:0] rsel_sync_r;
  logic [1:0] chain_sync_r;
  logic       cnv_prev_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnv_sync_r   <= 2'h0;
      rsel_sync_r  <= 2'h3;
      chain_sync_r <= 2'h0;
      cnv_prev_r   <= 1'b0;
    end else begin
      cnv_sync_r   <= {cnv_sync_r[0], convert_start};
      rsel_sync_r  <= {rsel_sync_r[0], read_select_or_link_in};
      chain_sync_r <= {chain_sync_r[0], chain_select};
      cnv_prev_r   <= cnv_sync_r[1];
    end
  end
  wire cnv_rise = cnv_sync_r[1] & ~cnv_prev_r;
  wire rsel_lo  = ~rsel_sync_r[1];
  wire chain_on = chain_sync_r[1];

  // ****************************************
  // Two-entry result buffer
  // ****************************************
  logic [19:0] buf_mem_r [2];
  logic        wr_ptr_r;
  logic        rd_ptr_r;
  logic [1:0]  count_r;
  logic        pop;
  wire         buf_push  = conv_valid & conv_ready;
  wire         buf_valid = (count_r != 2'h0);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      buf_mem_r[0] <= asr_pkg::RESULT_RST;
      buf_mem_r[1] <= asr_pkg::RESULT_RST;
      wr_ptr_r     <= 1'b0;
      rd_ptr_r     <= 1'b0;
      count_r      <= 2'h0;
      conv_ready   <= 1'b1;
    end else begin
      if (buf_push)
        buf_mem_r[wr_ptr_r] <= conv_data;
      if (buf_push)
        wr_ptr_r <= ~wr_ptr_r;
      if (pop)
        rd_ptr_r <= ~rd_ptr_r;
      count_r    <= count_r + {1'b0, buf_push} - {1'b0, pop};
      conv_ready <= (count_r + {1'b0, buf_push} - {1'b0, pop}) != 2'h2;
    end
  end

  // ****************************************
  // Conversion timer and busy
  // ****************************************
  logic [asr_pkg::CNT_W-1:0] conv_cnt_r;
  logic [19:0]               word_r;
  logic                      word_tog_r;
  wire conv_done = busy & (conv_cnt_r == asr_pkg::CNT_W'(CONV_CYCLES - 1));
  assign pop = conv_done & buf_valid;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy       <= 1'b0;
      conv_cnt_r <= '0;
      word_r     <= asr_pkg::RESULT_RST;
      word_tog_r <= 1'b0;
    end else if (!busy) begin
      busy       <= cnv_rise; // [R15] [R16]
      conv_cnt_r <= '0;
    end else begin
      conv_cnt_r <= conv_cnt_r + 1'b1;
      if (conv_done) begin
        busy       <= 1'b0; // [R16]
        word_r     <= buf_valid ? buf_mem_r[rd_ptr_r] : word_r;
        word_tog_r <= ~word_tog_r;
      end
    end
  end

  // ****************************************
  // Shift-clock domain
  // ****************************************
  logic [2:0]  tog_sync_r;
  logic [19:0] shreg_r;
  logic [1:0]  sel_sync_r;
  logic [1:0]  chn_sync_r;
  wire         load_now = tog_sync_r[2] ^ tog_sync_r[1];
  always_ff @(posedge shift_clk or negedge rstn) begin
    if (!rstn) begin
      tog_sync_r <= 3'h0;
      sel_sync_r <= 2'h3;
      chn_sync_r <= 2'h0;
      shreg_r    <= asr_pkg::RESULT_RST;
    end else begin
      tog_sync_r <= {tog_sync_r[1:0], word_tog_r};
      sel_sync_r <= {sel_sync_r[0], rsel_lo};
      chn_sync_r <= {chn_sync_r[0], chain_on};
      if (load_now)
        shreg_r <= word_r; // [R4] [R14]
      else if (chn_sync_r[1])
        shreg_r <= {shreg_r[18:0], read_select_or_link_in}; // [R9] [R11] [R12] [R10] [R13]
      else if (sel_sync_r[1])
        shreg_r <= {shreg_r[18:0], 1'b0}; // [R13]
    end
  end

  // ****************************************
  // Output driver
  // ****************************************
  logic [1:0] so_sync_r;
  wire        oe_nxt = chain_on | rsel_lo; // [R1] [R2] [R3] [R8]
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      so_sync_r            <= 2'h0;
      serial_result_out_oe <= 1'b0;
      serial_result_out_o  <= 1'b0;
    end else begin
      so_sync_r            <= {so_sync_r[0], shreg_r[19]};
      serial_result_out_oe <= oe_nxt; // [R7]
      serial_result_out_o  <= so_sync_r[1];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_hiz_when_idle: assert property (@(posedge core_clk) disable iff (!rstn)
    (!chain_on && !rsel_lo) |=> !serial_result_out_oe) else $error("output driven while deselected"); // [R2]
  a_drive_when_sel: assert property (@(posedge core_clk) disable iff (!rstn)
    (!chain_on && rsel_lo) |=> serial_result_out_oe) else $error("output not driven while selected"); // [R3]
  a_chain_drive: assert property (@(posedge core_clk) disable iff (!rstn)
    chain_on |=> serial_result_out_oe) else $error("chain output not enabled"); // [R8]
  a_busy_start: assert property (@(posedge core_clk) disable iff (!rstn)
    (!busy && cnv_rise) |=> busy) else $error("conversion did not start"); // [R15]
  a_busy_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(busy) |-> busy[*8]) else $error("busy dropped early"); // [R16]
  a_busy_end: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(busy) |-> $past(conv_cnt_r) == asr_pkg::CNT_W'(CONV_CYCLES - 1)) else $error("busy length wrong"); // [R16]
  a_word_flip: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(busy) |-> word_tog_r != $past(word_tog_r)) else $error("no result handoff"); // [R4]
  a_shift_chain: assert property (@(posedge shift_clk) disable iff (!rstn)
    (chn_sync_r[1] && !load_now) |=> shreg_r[0] == $past(read_select_or_link_in)) else $error("chain input lost"); // [R11]

  // ****************************************
  // Check helpers, core domain
  // ****************************************
  logic [asr_pkg::CNT_W-1:0] busy_len_r;
  logic [7:0]                push_cnt_r;
  logic [7:0]                pop_cnt_r;
  wire  [asr_pkg::CNT_W-1:0] busy_len_nxt = busy ? busy_len_r + 1'b1 : '0;
  wire  [7:0]                push_cnt_nxt = push_cnt_r + {7'h00, buf_push};
  wire  [7:0]                pop_cnt_nxt  = pop_cnt_r + {7'h00, pop};
  wire  [7:0]                fill_diff    = push_cnt_r - pop_cnt_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy_len_r <= '0;
      push_cnt_r <= 8'h00;
      pop_cnt_r  <= 8'h00;
    end else begin
      busy_len_r <= busy_len_nxt;
      push_cnt_r <= push_cnt_nxt;
      pop_cnt_r  <= pop_cnt_nxt;
    end
  end

  // ****************************************
  // Check helpers, shift-clock domain
  // ****************************************
  logic [5:0]  bits_out_r;
  logic [19:0] loaded_r;
  logic [19:0] link_hist_r;
  wire         shift_en      = !load_now && (chn_sync_r[1] || sel_sync_r[1]);
  wire         hist_bit      = chn_sync_r[1] ? read_select_or_link_in : 1'b0;
  wire         bits_sat      = (bits_out_r == 6'h3f);
  wire  [5:0]  bits_out_nxt  = load_now ? 6'h00 : (shift_en && !bits_sat) ? bits_out_r + 6'h01 : bits_out_r;
  wire  [19:0] link_hist_nxt = shift_en ? {link_hist_r[18:0], hist_bit} : link_hist_r;
  always_ff @(posedge shift_clk or negedge rstn) begin
    if (!rstn) begin
      bits_out_r  <= 6'h00;
      loaded_r    <= asr_pkg::RESULT_RST;
      link_hist_r <= asr_pkg::RESULT_RST;
    end else begin
      bits_out_r  <= bits_out_nxt;
      link_hist_r <= link_hist_nxt;
      if (load_now)
        loaded_r <= word_r;
    end
  end

  // ****************************************
  // Core-domain checks
  // ****************************************
  a_busy_length: assert property (@(posedge core_clk) disable iff (!rstn) // [R16]
    $fell(busy)
    |-> busy_len_r == asr_pkg::CNT_W'(CONV_CYCLES))
    else $error("busy length differs from conversion time");

  a_busy_no_restart: assert property (@(posedge core_clk) disable iff (!rstn) // [R15]
    (busy && cnv_rise && !conv_done)
    |=> busy)
    else $error("conversion restarted while busy");

  a_count_steps: assert property (@(posedge core_clk) disable iff (!rstn) // [R16]
    (busy && !conv_done)
    |=> conv_cnt_r == $past(conv_cnt_r) + 1'b1)
    else $error("conversion timer skipped");

  a_idle_count: assert property (@(posedge core_clk) disable iff (!rstn) // [R15]
    !busy
    |=> conv_cnt_r == '0)
    else $error("conversion timer not cleared");

  a_fill_track: assert property (@(posedge core_clk) disable iff (!rstn) // [R4]
    1'b1
    |-> fill_diff == {6'h00, count_r})
    else $error("buffer fill count wrong");

  a_ready_level: assert property (@(posedge core_clk) disable iff (!rstn) // [R4]
    1'b1
    |-> conv_ready == (count_r != 2'h2))
    else $error("ready flag disagrees with fill");

  a_count_bound: assert property (@(posedge core_clk) disable iff (!rstn) // [R4]
    1'b1
    |-> count_r != 2'h3)
    else $error("buffer overfilled");

  a_push_room: assert property (@(posedge core_clk) disable iff (!rstn) // [R4]
    buf_push
    |-> count_r != 2'h2)
    else $error("push into full buffer");

  a_pop_data: assert property (@(posedge core_clk) disable iff (!rstn) // [R4]
    pop
    |-> buf_valid)
    else $error("pop from empty buffer");

  a_ready_after_pop: assert property (@(posedge core_clk) disable iff (!rstn) // [R4]
    (!conv_ready && pop && !buf_push)
    |=> conv_ready)
    else $error("ready not restored after pop");

  a_word_pop: assert property (@(posedge core_clk) disable iff (!rstn) // [R4]
    pop
    |=> word_r == $past(buf_mem_r[rd_ptr_r]))
    else $error("result word not taken from buffer");

  a_word_keep: assert property (@(posedge core_clk) disable iff (!rstn) // [R14]
    !pop
    |=> $stable(word_r))
    else $error("result word changed without pop");

  a_tog_once: assert property (@(posedge core_clk) disable iff (!rstn) // [R4]
    $changed(word_tog_r)
    |-> $past(conv_done))
    else $error("handoff outside conversion end");

  a_oe_normal: assert property (@(posedge core_clk) disable iff (!rstn) // [R1]
    !chain_on
    |=> serial_result_out_oe == $past(rsel_lo))
    else $error("normal mode enable not from select");

  a_oe_chain_enter: assert property (@(posedge core_clk) disable iff (!rstn) // [R8]
    $rose(chain_on)
    |=> serial_result_out_oe)
    else $error("chain entry did not enable output");

  a_out_sync: assert property (@(posedge core_clk) disable iff (!rstn) // [R13]
    1'b1
    |=> serial_result_out_o == $past(so_sync_r[1]))
    else $error("serial output not from synchroniser");

  // ****************************************
  // Shift-domain checks
  // ****************************************
  a_load_word: assert property (@(posedge shift_clk) disable iff (!rstn) // [R4] [R14]
    load_now
    |=> shreg_r == $past(word_r))
    else $error("shifter not loaded with result");

  a_bits_reset: assert property (@(posedge shift_clk) disable iff (!rstn) // [R14]
    load_now
    |=> bits_out_r == 6'h00)
    else $error("bit count not cleared on load");

  a_normal_shift: assert property (@(posedge shift_clk) disable iff (!rstn) // [R13]
    (!load_now && !chn_sync_r[1] && sel_sync_r[1])
    |=> shreg_r == {$past(shreg_r[18:0]), 1'b0})
    else $error("normal shift wrong");

  a_hold_idle: assert property (@(posedge shift_clk) disable iff (!rstn) // [R14]
    (!load_now && !chn_sync_r[1] && !sel_sync_r[1])
    |=> $stable(shreg_r))
    else $error("shifter moved while deselected");

  a_chain_forward: assert property (@(posedge shift_clk) disable iff (!rstn) // [R12]
    (!load_now && chn_sync_r[1])
    |=> shreg_r[19:1] == $past(shreg_r[18:0]))
    else $error("chain shift order wrong");

  a_hist_chain_bit: assert property (@(posedge shift_clk) disable iff (!rstn) // [R11]
    (!load_now && chn_sync_r[1])
    |=> link_hist_r[0] == $past(read_select_or_link_in))
    else $error("link history missed a bit");

  a_own_first: assert property (@(posedge shift_clk) disable iff (!rstn) // [R12]
    (bits_out_r < 6'd20)
    |-> shreg_r[19] == loaded_r[5'd19 - bits_out_r[4:0]])
    else $error("own result not shifted first");

  a_hist_match: assert property (@(posedge shift_clk) disable iff (!rstn) // [R10]
    (bits_out_r >= 6'd20)
    |-> shreg_r == link_hist_r)
    else $error("forwarded bits out of order");
endmodule

//--- asr_pkg.sv
// Constants for the serial result readout block.
// Assumes a 125 MHz core clock and a separate shift clock from the host.
// Overview of operation
// R1: With the chain strap low the block is in normal mode and read-select gates the output driver.
// R2: In normal mode with read-select high the serial output is not driven.
// R3: In normal mode with read-select low the serial output is driven.
// R4: With read-select low the top result bit is on the output when busy falls; the code loads it on the third rising shift-clock edge after.
// R5: The host selects only one of several sharing converters at a time.
// R6: The host idles all read-selects high and lowers each in turn between conversions.
// R7: When read-select falls the top bit of the result is placed on the output at once; the code enables the driver three core-clock edges later.
// R8: With the chain strap high the block is in chain mode and the output is always driven.
// R9: In chain mode the read-select pin is the serial input from the upstream converter.
// R10: In a two-converter chain the upstream top bit shows on the downstream output after 20 shift clocks.
// R11: In chain mode the upstream top bit is captured on the first rising shift-clock edge.
// R12: In chain mode the block is a 20-bit shift register, own result first then forwarded bits.
// R13: Output data changes on rising shift-clock edges and may be sampled on the next falling or rising edge; the code changes it on rising core_clk edges.
// R14: The top result bit stays valid until the first rising shift-clock edge.
// R15: A rising edge on convert-start begins a conversion.
// R16: Busy stays high for the whole conversion.
package asr_pkg;
  localparam int          RES_BITS      = 20;
  localparam int          CLK_MHZ       = 125;
  localparam int          CONV_TIME_NS  = 3000;
  localparam int          CONV_CYCLES   = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int          CNT_W         = 16;
  localparam logic [19:0] RESULT_RST    = 20'h00000;
endpackage

//--- asr_host.sv
// Host model: gated shift clock and an upstream converter's serial stream.
// Assumes the bench gates the clock per frame and loads the upstream word.
`timescale 1ns/100ps
module asr_host (
  input  wire logic        sh_en,
  input  wire logic        ld,
  input  wire logic [19:0] up_word,
  output logic             shift_clk,
  output logic             link_out
);
  logic [19:0] sr_r = 20'h00000;
  // Clock stands still outside frames
  initial begin
    shift_clk = 1'b0;
    #5;
    forever begin
      #32;
      shift_clk = sh_en ? ~shift_clk : 1'b0;
    end
  end
  always @(posedge ld) sr_r = up_word;
  always @(posedge shift_clk) sr_r <= #1 {sr_r[18:0], ~sr_r[0]};
  assign link_out = sr_r[19];
endmodule

//--- asr_readout_tb.sv
// Self-checking bench for the serial result readout.
// Assumes asr_host supplies the shift clock and the upstream stream.
`timescale 1ns/100ps
module asr_readout_tb;
  logic core_clk = 1'b0, rstn = 1'b0, chain_select = 1'b0, convert_start = 1'b0, rd_sel = 1'b1;
  logic conv_valid = 1'b0, sh_en = 1'b0, ld = 1'b0;
  logic [19:0] conv_data = 20'h00000, up_word = 20'h00000;
  logic [39:0] cat;
  wire shift_clk, link, conv_ready, busy, so, soe;
  int n_fail = 0, checked = 0, i, k;
  asr_host host (.sh_en(sh_en), .ld(ld), .up_word(up_word), .shift_clk(shift_clk), .link_out(link));
  asr_readout #(.CONV_CYCLES(10)) dut (.core_clk(core_clk), .rstn(rstn), .shift_clk(shift_clk),
    .chain_select(chain_select), .convert_start(convert_start),
    .read_select_or_link_in(chain_select ? link : rd_sel), .conv_data(conv_data),
    .conv_valid(conv_valid), .conv_ready(conv_ready), .busy(busy),
    .serial_result_out_o(so), .serial_result_out_oe(soe));
  initial forever #4 core_clk = ~core_clk;
  // ********************
  // Checking and closing
  // ********************
  task automatic summarize;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic lim;
    if (i >= 50) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic shift(input int n);
    sh_en = 1'b1;
    repeat (n) begin
      for (i = 0; i < 50 && shift_clk !== 1'b1; i++) @(negedge core_clk);
      lim();
      for (i = 0; i < 50 && shift_clk !== 1'b0; i++) @(negedge core_clk);
      lim();
    end
    sh_en = 1'b0;
  endtask
  task automatic conv(input logic [19:0] w);
    @(negedge core_clk);
    conv_data = w;
    conv_valid = 1'b1;
    for (i = 0; i < 50 && conv_ready !== 1'b1; i++) @(negedge core_clk);
    lim();
    @(negedge core_clk);
    conv_valid = 1'b0;
    convert_start = 1'b1;
    for (i = 0; i < 50 && busy !== 1'b1; i++) @(negedge core_clk);
    lim();
    convert_start = 1'b0;
    for (i = 0; i < 50 && busy === 1'b1; i++) @(negedge core_clk);
    lim();
    chk("busy_cycles", i, 20'h0000a);
  endtask
  task automatic t_normal;
    repeat (5) @(negedge core_clk);
    chk("oe_deselected", soe, 1'b0);
    conv(20'ha5c93);
    rd_sel = 1'b0;
    repeat (5) @(negedge core_clk);
    chk("oe_selected", soe, 1'b1);
    shift(3);
    chk("top_bit", so, 1'b1);
    for (k = 18; k >= 0; k--) begin
      shift(1);
      chk("normal_bit", so, cat[k]);
    end
    rd_sel = 1'b1;
  endtask
  task automatic t_chain;
    chain_select = 1'b1;
    repeat (5) @(negedge core_clk);
    chk("oe_chain", soe, 1'b1);
    conv(20'h3c6e1);
    shift(3);
    up_word = 20'hc0f35;
    ld = 1'b1;
    cat = {20'h3c6e1, 20'hc0f35};
    for (k = 39; k >= 0; k--) begin
      chk("chain_bit", so, cat[k]);
      shift(1);
    end
  endtask
  task automatic t_buf;
    repeat (2) begin
      @(negedge core_clk);
      conv_valid = 1'b1;
      @(negedge core_clk);
    end
    conv_valid = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("buffer_full", conv_ready, 1'b0);
  endtask
  initial begin
    cat = {20'h00000, 20'ha5c93};
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    t_normal();
    t_chain();
    t_buf();
    summarize();
  end
endmodule
